// File: hw/irbi_top.sv
// isochronous receive interrupt registers and bus-resource init values
`timescale 1ns/1ps
`default_nettype none
`include "irbi_params.svh"

module irbi_top (
   input  wire logic                     i_clk,      // 40 MHz clock
   input  wire logic                     i_srst,     // hardware reset, sync high
   input  wire logic                     i_sw_rst,   // software reset pulse
   input  wire logic                     i_hbus_rst, // host-bus reset pulse
   input  wire logic                     i_bus_rst,  // serial-bus reset pulse
   input  wire irbi_pkg::irbi_ctx_type   i_rx_irq,   // per-context interrupt
   input  wire irbi_pkg::irbi_ahb_req_type i_ahb,    // AHB-Lite request
   output var  irbi_pkg::irbi_ahb_rsp_type o_ahb,    // AHB-Lite response
   output var  irbi_pkg::irbi_csr_type   o_csr,      // bus-management CSR preload
   output logic                          o_rx_summary_event // interrupt level
);
   import irbi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state

   localparam irbi_regs_type RST_VAL = '{
      bus_st:    ST_IDLE,
      regsel:    '0,
      hready:    1'b1,
      hrdata:    '0,
      flags:     '0,
      mask:      '0,
      irq_prev:  '0,
      bw_init:   `IRBI_BW_RST,
      chan_init: `IRBI_CH_RST,
      csr:       '{bw: `IRBI_BW_RST, chan_hi: `IRBI_CH_RST, load: 1'b1},
      summary:   1'b0
   };

   irbi_regs_type r_q;
   irbi_regs_type r_d;

   logic           acc;
   irbi_sel_type   sel;
   logic           wr_en;
   irbi_sel_type   wsel;
   logic [31:0]    wdata;
   irbi_ctx_type   rise;
   irbi_ctx_type   ev_set;
   irbi_ctx_type   ev_clr;
   irbi_ctx_type   mk_set;
   irbi_ctx_type   mk_clr;
   logic           rst_copy;
   logic [31:0]    rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // bus address phase and decode

   assign acc = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1];

   // full-address compare: aliases above the window read as zero
   assign sel[`IRBI_SEL_EVSET] = (i_ahb.haddr == `IRBI_OFS_EVSET);
   assign sel[`IRBI_SEL_EVCLR] = (i_ahb.haddr == `IRBI_OFS_EVCLR);
   assign sel[`IRBI_SEL_MKSET] = (i_ahb.haddr == `IRBI_OFS_MKSET);
   assign sel[`IRBI_SEL_MKCLR] = (i_ahb.haddr == `IRBI_OFS_MKCLR);
   assign sel[`IRBI_SEL_BW]    = (i_ahb.haddr == `IRBI_OFS_BW);
   assign sel[`IRBI_SEL_CH]    = (i_ahb.haddr == `IRBI_OFS_CH);

   assign wr_en = (r_q.bus_st == ST_WR);
   assign wsel  = wr_en ? r_q.regsel : '0;
   assign wdata = i_ahb.hwdata;

   ////////////////////////////////////////////////////////////////////////////
   // event and mask updates

   assign rise = i_rx_irq & ~r_q.irq_prev;

   assign ev_set = rise
                 | (wsel[`IRBI_SEL_EVSET] ? wdata[`IRBI_CTX_N-1:0] : '0);
   assign ev_clr = wsel[`IRBI_SEL_EVCLR] ? wdata[`IRBI_CTX_N-1:0] : '0;
   assign mk_set = wsel[`IRBI_SEL_MKSET] ? wdata[`IRBI_CTX_N-1:0] : '0;
   assign mk_clr = wsel[`IRBI_SEL_MKCLR] ? wdata[`IRBI_CTX_N-1:0] : '0;

   assign rst_copy = i_hbus_rst | i_bus_rst;

   ////////////////////////////////////////////////////////////////////////////
   // read mux, upper bits zero-filled

   assign rd_word =
        ({{(32-`IRBI_CTX_N){1'b0}}, r_q.flags}
           & {32{r_q.regsel[`IRBI_SEL_EVSET]}})
      | ({{(32-`IRBI_CTX_N){1'b0}}, r_q.flags & r_q.mask}
           & {32{r_q.regsel[`IRBI_SEL_EVCLR]}})
      | ({{(32-`IRBI_CTX_N){1'b0}}, r_q.mask}
           & {32{r_q.regsel[`IRBI_SEL_MKSET]
               | r_q.regsel[`IRBI_SEL_MKCLR]}})
      | ({{(32-`IRBI_BW_W){1'b0}}, r_q.bw_init}
           & {32{r_q.regsel[`IRBI_SEL_BW]}})
      | (r_q.chan_init & {32{r_q.regsel[`IRBI_SEL_CH]}});

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_d = r_q;
      r_d.irq_prev = i_rx_irq;

      // set wins over a clear in the same cycle, so no edge is lost
      r_d.flags = (r_q.flags & ~ev_clr) | ev_set;
      r_d.mask  = (r_q.mask & ~mk_clr) | mk_set;

      // registered from next values so the line tracks the flags exactly
      r_d.summary = |(r_d.flags & r_d.mask);

      if (i_sw_rst) begin
         r_d.bw_init   = `IRBI_BW_RST;
         r_d.chan_init = `IRBI_CH_RST;
      end else begin
         if (wsel[`IRBI_SEL_BW]) begin
            r_d.bw_init = wdata[`IRBI_BW_W-1:0];
         end
         if (wsel[`IRBI_SEL_CH]) begin
            r_d.chan_init = wdata;
         end
      end

      // a bus or host-bus reset copies the value held before any write in the same cycle
      r_d.csr.load = i_sw_rst | rst_copy;
      if (i_sw_rst) begin
         r_d.csr.bw      = `IRBI_BW_RST;
         r_d.csr.chan_hi = `IRBI_CH_RST;
      end else if (rst_copy) begin
         r_d.csr.bw      = r_q.bw_init;
         r_d.csr.chan_hi = r_q.chan_init;
      end

      r_d.hready = 1'b1;
      case (r_q.bus_st)
         ST_IDLE, ST_WR: begin
            if (acc) begin
               r_d.regsel = sel;
               r_d.bus_st = i_ahb.hwrite ? ST_WR : ST_RD;
               // one wait state on reads lets a preceding write land first
               r_d.hready = i_ahb.hwrite;
            end else begin
               r_d.bus_st = ST_IDLE;
            end
         end
         ST_RD: begin
            r_d.hrdata = rd_word;
            r_d.bus_st = ST_IDLE;
         end
         default: begin
            r_d.bus_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_q <= RST_VAL;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // one assignment drives the whole response struct
   assign o_ahb = '{
      hrdata:    r_q.hrdata,
      hreadyout: r_q.hready,
      hresp:     `IRBI_RESP_OKAY
   };
   assign o_csr           = r_q.csr;
   assign o_rx_summary_event = r_q.summary;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_flag_rise: assert property (
      (|rise) |=> ((r_q.flags & $past(rise)) == $past(rise)))
      else $error("context edge did not set its flag");

   a_flag_only_clr: assert property (
      (!$past(i_srst) && (|($past(r_q.flags) & ~r_q.flags)))
      |-> ($past(wr_en) && $past(r_q.regsel[`IRBI_SEL_EVCLR])))
      else $error("flag fell without a clear write");

   a_set_wins: assert property (
      (|(ev_set & ev_clr)) |=> ((r_q.flags & $past(ev_set)) == $past(ev_set)))
      else $error("clear beat a simultaneous set");

   a_ev_rsvd: assert property (
      (r_q.bus_st == ST_RD && (|r_q.regsel[`IRBI_SEL_MKCLR:`IRBI_SEL_EVSET]))
      |=> (r_q.hrdata[31:`IRBI_CTX_N] == '0))
      else $error("reserved event or mask bits read nonzero");

   a_clr_read: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_EVCLR])
      |=> (r_q.hrdata[`IRBI_CTX_N-1:0] == $past(r_q.flags & r_q.mask)))
      else $error("clear address read is not flags and mask");

   a_mask_read: assert property (
      (r_q.bus_st == ST_RD
       && (r_q.regsel[`IRBI_SEL_MKSET] || r_q.regsel[`IRBI_SEL_MKCLR]))
      |=> (r_q.hrdata[`IRBI_CTX_N-1:0] == $past(r_q.mask)))
      else $error("mask read differs from mask");

   a_mask_set: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_MKSET])
      |=> ((r_q.mask & $past(wdata[`IRBI_CTX_N-1:0]))
           == $past(wdata[`IRBI_CTX_N-1:0])))
      else $error("mask set write did not set bits");

   a_summary_qual: assert property (
      o_rx_summary_event == (|(r_q.flags & r_q.mask)))
      else $error("summary event not flags and mask");

   a_bw_rsvd: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_BW])
      |=> (r_q.hrdata[31:`IRBI_BW_W] == '0))
      else $error("bandwidth reserved bits nonzero");

   a_init_swrst: assert property (
      i_sw_rst |=> (r_q.bw_init == `IRBI_BW_RST
                    && r_q.chan_init == `IRBI_CH_RST))
      else $error("software reset left init values");

   a_init_keep: assert property (
      (i_bus_rst && !i_sw_rst && !wr_en) |=> $stable(r_q.bw_init)
                                         && $stable(r_q.chan_init))
      else $error("bus reset changed init values");

   a_csr_copy: assert property (
      (rst_copy && !i_sw_rst) |=> (o_csr.load
                                   && o_csr.bw == $past(r_q.bw_init)
                                   && o_csr.chan_hi == $past(r_q.chan_init)))
      else $error("reset did not copy init to CSR");

   a_read_wait: assert property (
      (acc && !i_ahb.hwrite && r_q.hready) |=> !o_ahb.hreadyout ##1 o_ahb.hreadyout)
      else $error("read wait state wrong");

   a_flag_wset: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_EVSET])
      |=> ((r_q.flags & $past(wdata[`IRBI_CTX_N-1:0]))
           == $past(wdata[`IRBI_CTX_N-1:0])))
      else $error("set write did not set flags");

   a_flag_clr: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_EVCLR] && !(|rise))
      |=> ((r_q.flags & $past(wdata[`IRBI_CTX_N-1:0])) == '0))
      else $error("clear write left a flag set");

   // a flag may only appear for its own context edge or a set write
   a_flag_cause: assert property (
      (!$past(i_srst))
      |-> ((r_q.flags & ~$past(r_q.flags) & ~$past(rise)
            & ~$past(wsel[`IRBI_SEL_EVSET] ? wdata[`IRBI_CTX_N-1:0] : '0)) == '0))
      else $error("flag set with no cause");

   a_set_read: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_EVSET])
      |=> (r_q.hrdata[`IRBI_CTX_N-1:0] == $past(r_q.flags)))
      else $error("set address read is not raw flags");

   a_mask_clr: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_MKCLR])
      |=> ((r_q.mask & $past(wdata[`IRBI_CTX_N-1:0])) == '0))
      else $error("mask clear write left bits set");

   a_mask_zeros: assert property (
      (wr_en && (r_q.regsel[`IRBI_SEL_MKSET] || r_q.regsel[`IRBI_SEL_MKCLR]))
      |=> ((r_q.mask & ~$past(wdata[`IRBI_CTX_N-1:0]))
           == ($past(r_q.mask) & ~$past(wdata[`IRBI_CTX_N-1:0]))))
      else $error("written zero changed a mask bit");

   a_mask_only: assert property (
      !wr_en |=> $stable(r_q.mask))
      else $error("mask moved without a write");

   a_bw_write: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_BW] && !i_sw_rst)
      |=> (r_q.bw_init == $past(wdata[`IRBI_BW_W-1:0])))
      else $error("bandwidth write did not land");

   a_bw_read: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_BW])
      |=> (r_q.hrdata[`IRBI_BW_W-1:0] == $past(r_q.bw_init)))
      else $error("bandwidth read differs from register");

   a_ch_write: assert property (
      (wr_en && r_q.regsel[`IRBI_SEL_CH] && !i_sw_rst)
      |=> (r_q.chan_init == $past(wdata)))
      else $error("channels write did not land");

   a_ch_read: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_CH])
      |=> (r_q.hrdata == $past(r_q.chan_init)))
      else $error("channels read differs from register");

   a_unmapped_rd: assert property (
      (r_q.bus_st == ST_RD && r_q.regsel == '0)
      |=> (r_q.hrdata == '0))
      else $error("unmapped read returned data");

   a_init_only: assert property (
      (!wr_en && !i_sw_rst) |=> $stable(r_q.bw_init) && $stable(r_q.chan_init))
      else $error("init values moved without write or reset");

   a_swrst_csr: assert property (
      i_sw_rst |=> (o_csr.load && o_csr.bw == `IRBI_BW_RST
                    && o_csr.chan_hi == `IRBI_CH_RST))
      else $error("software reset did not preload defaults");

   // attempts that begin on the edge releasing reset see the reset image,
   // so quiet-cycle checks also want reset low where they start
   a_csr_idle: assert property (
      (!i_srst && !rst_copy && !i_sw_rst)
      |=> (!o_csr.load && $stable(o_csr.bw) && $stable(o_csr.chan_hi)))
      else $error("CSR preload moved without a reset");

   a_hbus_copy: assert property (
      (i_hbus_rst && !i_sw_rst) |=> (o_csr.chan_hi == $past(r_q.chan_init)))
      else $error("host-bus reset did not copy channels");

   a_summary_rise: assert property (
      (|(rise & r_q.mask) && !wr_en) |=> o_rx_summary_event)
      else $error("unmasked edge did not raise summary");

   a_write_nowait: assert property (
      (acc && i_ahb.hwrite) |=> o_ahb.hreadyout)
      else $error("write inserted a wait state");

   a_rdata_hold: assert property (
      (r_q.bus_st != ST_RD) |=> $stable(r_q.hrdata))
      else $error("read data moved outside a read");

   c_clr_read: cover property (
      r_q.bus_st == ST_RD && r_q.regsel[`IRBI_SEL_EVCLR]);

   c_bus_copy: cover property (i_bus_rst ##1 o_csr.load);

   c_set_clr: cover property (|(ev_set & ev_clr));

   c_irq_line: cover property ((|rise) ##2 o_rx_summary_event);

   c_sw_reset: cover property (i_sw_rst ##1 o_csr.load);

endmodule : irbi_top

`default_nettype wire

// File: hw/irbi_params.svh
// constants for the receive interrupt and bus-resource init register block
`ifndef IRBI_PARAMS_SVH
`define IRBI_PARAMS_SVH

`define IRBI_CTX_N     4
`define IRBI_BW_W      13
`define IRBI_NREG      6

`define IRBI_OFS_EVSET 32'h0000_00A0
`define IRBI_OFS_EVCLR 32'h0000_00A4
`define IRBI_OFS_MKSET 32'h0000_00A8
`define IRBI_OFS_MKCLR 32'h0000_00AC
`define IRBI_OFS_BW    32'h0000_00B0
`define IRBI_OFS_CH    32'h0000_00B4

`define IRBI_SEL_EVSET 0
`define IRBI_SEL_EVCLR 1
`define IRBI_SEL_MKSET 2
`define IRBI_SEL_MKCLR 3
`define IRBI_SEL_BW    4
`define IRBI_SEL_CH    5

`define IRBI_BW_RST    13'h1333
`define IRBI_CH_RST    32'hFFFF_FFFF
`define IRBI_RESP_OKAY 1'h0

`endif

// File: hw/irbi_pkg.sv
// types shared by the receive interrupt and bus-resource init register block
`default_nettype none
`include "irbi_params.svh"

package irbi_pkg;

   typedef logic [`IRBI_CTX_N-1:0] irbi_ctx_type;
   typedef logic [`IRBI_NREG-1:0]  irbi_sel_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WR   = 3'b010,
      ST_RD   = 3'b100
   } irbi_state_type;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } irbi_ahb_req_type;

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } irbi_ahb_rsp_type;

   typedef struct packed {
      logic [`IRBI_BW_W-1:0] bw;
      logic [31:0]           chan_hi;
      logic                  load;
   } irbi_csr_type;

   typedef struct packed {
      irbi_state_type        bus_st;
      irbi_sel_type          regsel;
      logic                  hready;
      logic [31:0]           hrdata;
      irbi_ctx_type          flags;
      irbi_ctx_type          mask;
      irbi_ctx_type          irq_prev;
      logic [`IRBI_BW_W-1:0] bw_init;
      logic [31:0]           chan_init;
      irbi_csr_type          csr;
      logic                  summary;
   } irbi_regs_type;

endpackage : irbi_pkg

`default_nettype wire

// File: bench/irbi_top_tb_top.sv
// self-checking bench for the receive interrupt and bus-resource init registers
`timescale 1ns/1ps
`default_nettype none
`include "irbi_params.svh"

module irbi_top_tb_top import irbi_pkg::*;;
   logic             i_clk;
   logic             i_srst;
   logic             sw_rst;
   logic             hbus_rst;
   logic             bus_rst;
   irbi_ctx_type     rx_irq;
   irbi_ahb_req_type ahb_q;
   irbi_ahb_req_type ahb_in;
   irbi_ahb_rsp_type ahb_rsp;
   irbi_csr_type     csr;
   logic             summary;
   logic [31:0]      rd;
   int               bad_count = 0;
   int               checks = 0;
   int               cyc = 0;

   // single slave: its hreadyout is the bus hready
   always_comb begin
      ahb_in = ahb_q;
      ahb_in.hready = ahb_rsp.hreadyout;
   end

   irbi_top dut_u (
      .i_clk              (i_clk),
      .i_srst             (i_srst),
      .i_sw_rst           (sw_rst),
      .i_hbus_rst         (hbus_rst),
      .i_bus_rst          (bus_rst),
      .i_rx_irq           (rx_irq),
      .i_ahb              (ahb_in),
      .o_ahb              (ahb_rsp),
      .o_csr              (csr),
      .o_rx_summary_event (summary)
   );

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // the whole run needs under two hundred cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask : tick

   // entered right after a rising edge; holds each phase until hready is sampled high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      ahb_q <= '{1'b1, a, 2'h2, wr, 3'h2, ahb_q.hwdata, 1'b1};
      do begin
         @(posedge i_clk);
      end while (ahb_rsp.hreadyout !== 1'b1);
      ahb_q <= '{1'b0, a, 2'h0, wr, 3'h2, wd, 1'b1};
      do begin
         @(posedge i_clk);
      end while (ahb_rsp.hreadyout !== 1'b1);
      rd = ahb_rsp.hrdata;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string m);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp, m);
      chk({31'h0, ahb_rsp.hresp}, 32'h0000_0000, "hresp okay");
   endtask : rdc

   // k: 0 serial-bus reset, 1 host-bus reset, 2 software reset
   task automatic pulse(input int k);
      sw_rst <= (k == 2);
      hbus_rst <= (k == 1);
      bus_rst <= (k == 0);
      tick(1);
      {sw_rst, hbus_rst, bus_rst} <= 3'h0;
      tick(1);
      chk({31'h0, csr.load}, 32'h0000_0001, "load pulse");
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(`IRBI_OFS_BW, 32'h0000_1333, "bw reset");
      rdc(`IRBI_OFS_CH, 32'hFFFF_FFFF, "ch reset");
      chk({19'h0, csr.bw}, 32'h0000_1333, "csr bw");
      chk(csr.chan_hi, 32'hFFFF_FFFF, "csr ch");
      rdc(32'h0000_00C0, 32'h0000_0000, "unmapped read");
      $display("test reset done");
   endtask : t_reset

   task automatic t_init();
      wr(`IRBI_OFS_BW, 32'hFFFF_FFFF);
      rdc(`IRBI_OFS_BW, 32'h0000_1FFF, "bw width");
      wr(`IRBI_OFS_CH, 32'hA5A5_5A5A);
      wr(32'h0000_00BC, 32'h0000_0000);
      rdc(`IRBI_OFS_CH, 32'hA5A5_5A5A, "ch rw");
      pulse(0);
      chk({19'h0, csr.bw}, 32'h0000_1FFF, "bus rst bw");
      chk(csr.chan_hi, 32'hA5A5_5A5A, "bus rst ch");
      rdc(`IRBI_OFS_BW, 32'h0000_1FFF, "bw kept");
      wr(`IRBI_OFS_CH, 32'h1234_5678);
      pulse(1);
      chk(csr.chan_hi, 32'h1234_5678, "host rst ch");
      pulse(2);
      rdc(`IRBI_OFS_BW, 32'h0000_1333, "sw rst bw");
      rdc(`IRBI_OFS_CH, 32'hFFFF_FFFF, "sw rst ch");
      chk({19'h0, csr.bw}, 32'h0000_1333, "sw rst csr");
      $display("test init done");
   endtask : t_init

   task automatic t_mask();
      wr(`IRBI_OFS_MKSET, 32'hFFFF_FFFF);
      rdc(`IRBI_OFS_MKSET, 32'h0000_000F, "mask upper");
      rdc(`IRBI_OFS_MKCLR, 32'h0000_000F, "mask at clr");
      wr(`IRBI_OFS_MKCLR, 32'h0000_0005);
      rdc(`IRBI_OFS_MKSET, 32'h0000_000A, "mask clr");
      wr(`IRBI_OFS_MKSET, 32'h0000_0000);
      rdc(`IRBI_OFS_MKCLR, 32'h0000_000A, "mask zeros");
      $display("test mask done");
   endtask : t_mask

   // mask is 4'hA here, so only contexts 1 and 3 reach the summary
   task automatic t_flags();
      wr(`IRBI_OFS_EVCLR, 32'h0000_000F);
      for (int n = 0; n < 4; n++) begin
         rx_irq <= 4'h1 << n;
         tick(2);
         rdc(`IRBI_OFS_EVSET, 32'h1 << n, "ctx flag");
         chk({31'h0, summary}, {31'h0, n[0]}, "summary ctx");
         wr(`IRBI_OFS_EVCLR, 32'h1 << n);
         rdc(`IRBI_OFS_EVSET, 32'h0000_0000, "held level");
         rx_irq <= 4'h0;
         tick(1);
      end
      wr(`IRBI_OFS_EVSET, 32'hFFFF_FFFC);
      rdc(`IRBI_OFS_EVSET, 32'h0000_000C, "set upper");
      rdc(`IRBI_OFS_EVCLR, 32'h0000_0008, "masked read");
      chk({31'h0, summary}, 32'h0000_0001, "summary on");
      wr(`IRBI_OFS_EVSET, 32'h0000_0000);
      wr(`IRBI_OFS_MKCLR, 32'h0000_0008);
      rdc(`IRBI_OFS_EVCLR, 32'h0000_0000, "masked off");
      rdc(`IRBI_OFS_EVSET, 32'h0000_000C, "flags kept");
      chk({31'h0, summary}, 32'h0000_0000, "summary off");
      wr(`IRBI_OFS_EVCLR, 32'h0000_0004);
      rdc(`IRBI_OFS_EVSET, 32'h0000_0008, "w1 clear");
      // context 0 edge lands in the data phase of a clear write to its bit
      fork
         wr(`IRBI_OFS_EVCLR, 32'h0000_0001);
         begin
            @(posedge i_clk);
            rx_irq <= 4'h1;
         end
      join
      rdc(`IRBI_OFS_EVSET, 32'h0000_0009, "set beats clear");
      rx_irq <= 4'h0;
      $display("test flags done");
   endtask : t_flags

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_srst = 1'b1;
      sw_rst = 1'b0;
      hbus_rst = 1'b0;
      bus_rst = 1'b0;
      rx_irq = 4'h0;
      ahb_q = '0;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_init();
      t_mask();
      t_flags();
      print_verdict();
   end
endmodule : irbi_top_tb_top

`default_nettype wire
